// File: src/ssmt_pkg.sv
// Function
// - Legacy mode: empty flag clears only by write after reading it at one
// - Interrupt mode: empty pending flag clears itself when request is serviced
// - Polling: pending at one permits a write; software then clears it
// - Device sets end flag when transmission finishes; software then enables end irq
// - Software waits until control register reads zero after clearing enables; the test waits for irq to read zero instead
package ssmt_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] SSMT_ADDR_HOLD = 4'h0;
   localparam logic [3:0] SSMT_ADDR_CTRL = 4'h1;
   localparam logic [3:0] SSMT_ADDR_STAT = 4'h2;
   localparam logic [3:0] SSMT_ADDR_IRQC = 4'h3;
   localparam logic [3:0] SSMT_ADDR_PRIO = 4'h4;
   localparam logic [3:0] SSMT_ADDR_PMODE = 4'h5;
   localparam logic [3:0] SSMT_ADDR_BAUD = 4'h6;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SSMT_CTRL_TXEN = 0;
   localparam int SSMT_CTRL_EIE = 1;
   localparam int SSMT_CTRL_NIE = 2;
   localparam int SSMT_CTRL_LEGACY = 3;
   localparam int SSMT_ST_EMPTY = 0;
   localparam int SSMT_ST_END = 1;
   localparam int SSMT_IRQC_EPEND = 0;
   localparam int SSMT_IRQC_ECEN = 1;
   localparam int SSMT_IRQC_NCEN = 2;
   localparam int SSMT_PM_DATA = 0;
   localparam int SSMT_PM_CLK = 1;

   // ----------------------------------------------------------------
   // Reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [7:0] SSMT_BAUD_RST = 8'h77;
   localparam logic [7:0] SSMT_PRIO_RST = 8'h00;
   localparam logic [2:0] SSMT_BIT_LAST = 3'h7;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ssmt_bus_req_t;

   typedef struct packed {
      logic data_out;
      logic data_oe_n;
      logic clk_out;
      logic clk_oe_n;
   } ssmt_pins_t;

   typedef enum logic [2:0] {
      SSMT_IDLE = 3'b001,
      SSMT_LOW = 3'b010,
      SSMT_HIGH = 3'b100
   } ssmt_state_t;

endpackage : ssmt_pkg

// File: src/ssmt_baud.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Half-bit enable divider
// ----------------------------------------------------------------
module ssmt_baud (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic [7:0] div,
   // Enable out
   output logic tick
);
   import ssmt_pkg::*;

   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } ssmt_baud_st_t;

   ssmt_baud_st_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (!run) begin
         s_nxt.cnt = 8'h00;
      end else if (s_r.cnt >= div) begin
         s_nxt.cnt = 8'h00;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule // ssmt_baud

// File: src/ssmt_top.sv
`timescale 1ns/100ps
module ssmt_top (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire ssmt_pkg::ssmt_bus_req_t bus,
   output logic [7:0] rdata,
   // Serial pins
   output ssmt_pkg::ssmt_pins_t pins,
   // Interrupt
   output logic irq
);
   import ssmt_pkg::*;

   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] hold;
      logic hold_full;
      logic [7:0] shift;
      logic [2:0] bitn;
      ssmt_state_t st;
      logic txen;
      logic eie;
      logic nie;
      logic legacy;
      logic empty_flag;
      logic empty_seen;
      logic end_flag;
      logic epend;
      logic ecen;
      logic ncen;
      logic [7:0] prio;
      logic [1:0] pmode;
      logic [7:0] baud;
      ssmt_pins_t pins;
      logic irq;
   } ssmt_st_t;

   ssmt_st_t s_r, s_nxt;
   logic tick;
   logic wr_hold;
   logic rd_stat;
   logic load;
   logic shifting;

   ssmt_baud u_baud (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(shifting),
      .div(s_r.baud),
      .tick(tick)
   );

   assign shifting = (s_r.st != SSMT_IDLE);
   assign wr_hold = bus.wr && (bus.addr == SSMT_ADDR_HOLD);
   assign rd_stat = bus.rd && (bus.addr == SSMT_ADDR_STAT);
   // Byte moves to shifter when idle, or at end of last bit
   assign load = s_r.txen && s_r.hold_full &&
      ((s_r.st == SSMT_IDLE) || (s_r.st == SSMT_HIGH && tick && s_r.bitn == SSMT_BIT_LAST));

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdata = 8'h00;

      // ----------------------------------------------------------------
      // Register reads
      // ----------------------------------------------------------------
      if (bus.rd) begin
         unique case (bus.addr)
            SSMT_ADDR_HOLD: s_nxt.rdata = s_r.hold;
            SSMT_ADDR_CTRL: begin
               s_nxt.rdata = {4'h0, s_r.legacy, s_r.nie, s_r.eie, s_r.txen};
            end
            SSMT_ADDR_STAT: s_nxt.rdata = {6'h00, s_r.end_flag, s_r.empty_flag};
            SSMT_ADDR_IRQC: s_nxt.rdata = {5'h00, s_r.ncen, s_r.ecen, s_r.epend};
            SSMT_ADDR_PRIO: s_nxt.rdata = s_r.prio;
            SSMT_ADDR_PMODE: s_nxt.rdata = {6'h00, s_r.pmode};
            SSMT_ADDR_BAUD: s_nxt.rdata = s_r.baud;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
      // Read-before-clear tracking only counts in legacy mode
      s_nxt.empty_seen = s_r.legacy && (s_r.empty_seen || (rd_stat && s_r.empty_flag));

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (bus.wr) begin
         unique case (bus.addr)
            SSMT_ADDR_HOLD: begin
               s_nxt.hold = bus.wdata;
               s_nxt.hold_full = 1'b1;
               s_nxt.end_flag = 1'b0;
               // Writing data counts as servicing the request
               if (!s_r.legacy) begin
                  s_nxt.empty_flag = 1'b0;
                  if (s_r.ecen) begin
                     s_nxt.epend = 1'b0;
                  end
               end
            end
            SSMT_ADDR_CTRL: begin
               s_nxt.txen = bus.wdata[SSMT_CTRL_TXEN];
               s_nxt.eie = bus.wdata[SSMT_CTRL_EIE];
               s_nxt.nie = bus.wdata[SSMT_CTRL_NIE];
               s_nxt.legacy = bus.wdata[SSMT_CTRL_LEGACY];
            end
            SSMT_ADDR_STAT: begin
               // Legacy: zero written only after flag was read at one
               if (s_r.legacy && s_r.empty_seen && !bus.wdata[SSMT_ST_EMPTY]) begin
                  s_nxt.empty_flag = 1'b0;
                  s_nxt.empty_seen = 1'b0;
               end
            end
            SSMT_ADDR_IRQC: begin
               if (!bus.wdata[SSMT_IRQC_EPEND]) begin
                  s_nxt.epend = 1'b0;
               end
               s_nxt.ecen = bus.wdata[SSMT_IRQC_ECEN];
               s_nxt.ncen = bus.wdata[SSMT_IRQC_NCEN];
            end
            SSMT_ADDR_PRIO: s_nxt.prio = bus.wdata;
            SSMT_ADDR_PMODE: s_nxt.pmode = bus.wdata[1:0];
            SSMT_ADDR_BAUD: s_nxt.baud = bus.wdata;
            default: ;
         endcase
      end

      // ----------------------------------------------------------------
      // Shifter, LSB first, clock idles high
      // ----------------------------------------------------------------
      if (!s_r.txen) begin
         s_nxt.st = SSMT_IDLE;
         s_nxt.pins.clk_out = 1'b1;
         s_nxt.pins.data_out = 1'b1;
         s_nxt.empty_flag = 1'b1;
         s_nxt.end_flag = 1'b1;
         s_nxt.hold_full = 1'b0;
      end else begin
         unique case (s_r.st)
            SSMT_IDLE: ;
            SSMT_LOW: begin
               if (tick) begin
                  s_nxt.st = SSMT_HIGH;
                  s_nxt.pins.clk_out = 1'b1;
               end
            end
            SSMT_HIGH: begin
               if (tick) begin
                  if (s_r.bitn != SSMT_BIT_LAST) begin
                     s_nxt.bitn = s_r.bitn + 3'h1;
                     s_nxt.shift = {1'b1, s_r.shift[7:1]};
                     s_nxt.pins.data_out = s_r.shift[1];
                     s_nxt.pins.clk_out = 1'b0;
                     s_nxt.st = SSMT_LOW;
                  end else if (!load) begin
                     s_nxt.st = SSMT_IDLE;
                     s_nxt.end_flag = 1'b1;
                  end
               end
            end
            default: s_nxt.st = SSMT_IDLE;
         endcase
         if (load) begin
            s_nxt.shift = s_r.hold;
            // A byte written in the load cycle stays queued
            s_nxt.hold_full = wr_hold;
            s_nxt.bitn = 3'h0;
            s_nxt.pins.data_out = s_r.hold[0];
            s_nxt.pins.clk_out = 1'b0;
            s_nxt.st = SSMT_LOW;
            s_nxt.end_flag = 1'b0;
            // Set wins over a same-cycle clear
            s_nxt.empty_flag = 1'b1;
            s_nxt.epend = 1'b1;
         end
      end

      // ----------------------------------------------------------------
      // Pins and interrupt
      // ----------------------------------------------------------------
      s_nxt.pins.data_oe_n = !s_nxt.pmode[SSMT_PM_DATA];
      s_nxt.pins.clk_oe_n = !s_nxt.pmode[SSMT_PM_CLK];
      s_nxt.irq = (s_nxt.epend && s_nxt.eie && s_nxt.ecen) ||
         (s_nxt.end_flag && s_nxt.nie && s_nxt.ncen && s_nxt.txen);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.st <= SSMT_IDLE;
         s_r.baud <= SSMT_BAUD_RST;
         s_r.prio <= SSMT_PRIO_RST;
         s_r.empty_flag <= 1'b1;
         s_r.end_flag <= 1'b1;
         s_r.pins <= '{data_out: 1'b1, data_oe_n: 1'b1, clk_out: 1'b1, clk_oe_n: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.rdata;
   assign pins = s_r.pins;
   assign irq = s_r.irq;
endmodule // ssmt_top

// File: testbench/ssmt_checker.sv
`timescale 1ns/100ps
module ssmt_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Observed ports
   input wire ssmt_pkg::ssmt_bus_req_t bus,
   input wire logic [7:0] rdata,
   input wire ssmt_pkg::ssmt_pins_t pins,
   input wire logic irq
);
   import ssmt_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // Shadow of written registers
   // ----------------------------------------------------------------
   logic [3:0] ctrl_r;
   logic [7:0] prio_r;
   logic [1:0] pm_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= 4'h0;
         prio_r <= SSMT_PRIO_RST;
         pm_r <= 2'h0;
      end else if (bus.wr) begin
         if (bus.addr == SSMT_ADDR_CTRL) ctrl_r <= bus.wdata[3:0];
         if (bus.addr == SSMT_ADDR_PRIO) prio_r <= bus.wdata;
         if (bus.addr == SSMT_ADDR_PMODE) pm_r <= bus.wdata[1:0];
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_read_idle_zero: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("read data outside read slot");
   a_ctrl_read_back: assert property (bus.rd && bus.addr == SSMT_ADDR_CTRL
      |=> rdata[3:0] == $past(ctrl_r))
      else $error("control read back wrong");
   a_prio_read_back: assert property (bus.rd && bus.addr == SSMT_ADDR_PRIO
      |=> rdata == $past(prio_r))
      else $error("priority read back wrong");
   a_unmapped_zero: assert property (bus.rd && bus.addr > SSMT_ADDR_BAUD
      |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   // Abort may lift clock and data together
   a_sample_stable: assert property ($rose(pins.clk_out) && $past(ctrl_r[0])
      |-> $stable(pins.data_out))
      else $error("data moved at sampling edge");
   a_oe_from_mode: assert property ($stable(pm_r) [*3]
      |-> {pins.clk_oe_n, pins.data_oe_n} == ~pm_r)
      else $error("pin enable not following mode");
   a_idle_lines_high: assert property ((!ctrl_r[0]) [*3]
      |-> pins.clk_out && pins.data_out)
      else $error("lines not idle while disabled");
   a_irq_quiet_off: assert property ((ctrl_r[2:1] == 2'h0) [*3] |-> !irq)
      else $error("interrupt with enables cleared");
   c_clk_fall: cover property ($fell(pins.clk_out));
   c_irq_rise: cover property ($rose(irq));
   c_stat_read: cover property (bus.rd && bus.addr == SSMT_ADDR_STAT);
endmodule // ssmt_checker

bind ssmt_top ssmt_checker u_chk (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
   .pins(pins), .irq(irq));

// File: testbench/ssmt_rx_model.sv
`timescale 1ns/100ps
module ssmt_rx_model (
   // Reset
   input wire logic rst,
   // Serial pins
   input wire ssmt_pkg::ssmt_pins_t pins,
   // Received data
   output logic [7:0] got,
   output logic [7:0] cnt
);
   import ssmt_pkg::*;
   logic [7:0] sh;
   logic [2:0] n;
   // Released lines float high through pull-ups
   wire logic sck = pins.clk_oe_n | pins.clk_out;
   wire logic sd = pins.data_oe_n | pins.data_out;
   always @(posedge sck or posedge rst) begin
      if (rst) begin
         n = 3'h0;
         cnt = 8'h00;
         got = 8'h00;
         sh = 8'h00;
      end else begin
         sh = {sd, sh[7:1]};
         if (n == SSMT_BIT_LAST) begin
            got = sh;
            cnt = cnt + 8'h01;
         end
         n = n + 3'h1;
      end
   end
endmodule // ssmt_rx_model

// File: testbench/ssmt_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module ssmt_test;
   import ssmt_pkg::*;
   typedef struct packed {
      logic wr;
      logic [3:0] addr;
      logic [7:0] data;
   } ssmt_row_t;
   localparam ssmt_row_t ROWS [12] = '{
      '{1'b0, SSMT_ADDR_BAUD, SSMT_BAUD_RST}, '{1'b0, SSMT_ADDR_PRIO, 8'h00},
      '{1'b0, SSMT_ADDR_STAT, 8'h03}, '{1'b0, 4'hf, 8'h00},
      '{1'b1, SSMT_ADDR_PRIO, 8'h05}, '{1'b0, SSMT_ADDR_PRIO, 8'h05},
      '{1'b1, 4'h9, 8'hff}, '{1'b0, 4'h9, 8'h00},
      '{1'b1, SSMT_ADDR_CTRL, 8'h00}, '{1'b0, SSMT_ADDR_CTRL, 8'h00},
      '{1'b1, SSMT_ADDR_BAUD, 8'h03}, '{1'b0, SSMT_ADDR_BAUD, 8'h03}};
   logic sys_clk = 1'b0;
   logic rst;
   ssmt_bus_req_t bus;
   logic [7:0] rdata, got, cnt, exp_r, exp_q;
   ssmt_pins_t pins;
   logic irq, chk_q;
   int n_errors = 0;
   int tests_run = 0;
   ssmt_top dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .pins(pins), .irq(irq));
   ssmt_rx_model u_rx (.rst(rst), .pins(pins), .got(got), .cnt(cnt));
   always #10 sys_clk = ~sys_clk;
   // ----------------------------------------------------------------
   // Bus cycles and read check
   // ----------------------------------------------------------------
   task automatic io(input logic w, input logic [3:0] a, input logic [7:0] d);
      bus <= {a, d, w, !w};
      exp_r <= d;
      @(posedge sys_clk);
   endtask
   task automatic wait_irq(input logic lvl);
      for (int i = 0; i < 200 && irq !== lvl; i++) @(negedge sys_clk);
      @(posedge sys_clk);
   endtask
   always @(posedge sys_clk) begin
      chk_q <= bus.rd;
      exp_q <= exp_r;
   end
   always @(negedge sys_clk) begin
      if (chk_q === 1'b1) `CHK(rdata, exp_q)
   end
   task automatic wrap_up();
      $display("errors %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge sys_clk);
      n_errors++;
      wrap_up();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst <= 1'b1;
      bus = '0;
      exp_r = 8'h00;
      repeat (10) @(posedge sys_clk);
      `CHK({pins, irq, rdata}, 13'h1e00)
      rst <= 1'b0;
      @(posedge sys_clk);
      foreach (ROWS[i]) io(ROWS[i].wr, ROWS[i].addr, ROWS[i].data);
      // Interrupt driven transfer of two bytes
      io(1'b1, SSMT_ADDR_IRQC, 8'h00);
      io(1'b1, SSMT_ADDR_CTRL, 8'h07);
      io(1'b1, SSMT_ADDR_PMODE, 8'h03);
      io(1'b1, SSMT_ADDR_IRQC, 8'h02);
      io(1'b1, SSMT_ADDR_HOLD, 8'ha5);
      bus <= '0;
      wait_irq(1'b1);
      `CHK(irq, 1'b1)
      io(1'b1, SSMT_ADDR_HOLD, 8'h3c);
      bus <= '0;
      wait_irq(1'b0);
      `CHK(irq, 1'b0)
      wait_irq(1'b1);
      `CHK({irq, got}, 9'h1a5)
      io(1'b1, SSMT_ADDR_CTRL, 8'h05);
      io(1'b1, SSMT_ADDR_IRQC, 8'h00);
      bus <= '0;
      repeat (80) @(posedge sys_clk);
      io(1'b0, SSMT_ADDR_STAT, 8'h03);
      io(1'b1, SSMT_ADDR_IRQC, 8'h04);
      bus <= '0;
      wait_irq(1'b1);
      `CHK({irq, got, cnt}, 17'h13c02)
      io(1'b1, SSMT_ADDR_PMODE, 8'h02);
      io(1'b1, SSMT_ADDR_IRQC, 8'h00);
      io(1'b1, SSMT_ADDR_CTRL, 8'h01);
      bus <= '0;
      wait_irq(1'b0);
      `CHK(irq, 1'b0)
      // Legacy flag handling with polling
      io(1'b1, SSMT_ADDR_CTRL, 8'h09);
      io(1'b1, SSMT_ADDR_HOLD, 8'h0f);
      bus <= '0;
      repeat (4) @(posedge sys_clk);
      io(1'b1, SSMT_ADDR_STAT, 8'h02);
      io(1'b0, SSMT_ADDR_STAT, 8'h01);
      io(1'b1, SSMT_ADDR_STAT, 8'h02);
      io(1'b0, SSMT_ADDR_STAT, 8'h00);
      io(1'b0, SSMT_ADDR_IRQC, 8'h01);
      io(1'b1, SSMT_ADDR_IRQC, 8'h00);
      io(1'b0, SSMT_ADDR_IRQC, 8'h00);
      bus <= '0;
      repeat (80) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      `CHK({got, cnt}, 16'hff03)
      // Reset after the last byte has gone out returns every register to idle
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      `CHK({pins, irq, rdata}, 13'h1e00)
      rst <= 1'b0;
      @(posedge sys_clk);
      io(1'b0, SSMT_ADDR_CTRL, 8'h00);
      bus <= '0;
      repeat (2) @(posedge sys_clk);
      wrap_up();
   end
endmodule // ssmt_test
